// >>> design/cafd_core.sv
`timescale 1ns/1ps
module cafd_core #(
	parameter int INT_WORDS = cafd_pkg::INT_WORDS
) (
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic        clk_en,
	output logic [15:0]      prog_addr_q,
	output logic             prog_ext_q,
	input  wire logic [15:0] prog_rdata,
	output logic [15:0]      prog_wdata_q,
	output logic             prog_we_q,
	output logic [7:0]       data_raddr_q,
	input  wire logic [7:0]  data_rdata,
	output logic [7:0]       data_waddr_q,
	output logic [7:0]       data_wdata_q,
	output logic             data_we_q,
	input  wire logic [2:0]  sw_addr,
	input  wire logic [7:0]  sw_wdata,
	input  wire logic        sw_wr,
	input  wire logic        sw_rd,
	output logic [7:0]       sw_rdata_q
);
	cafd_pkg::cafd_state_t state_q;
	cafd_pkg::cafd_flags_t flags_q;
	cafd_pkg::cafd_flags_t flg_val;
	cafd_pkg::cafd_alu_t   alu;
	logic [15:0] ir_q;
	logic [15:0] pc_q;
	logic [7:0]  acc_q;
	logic [7:0]  pch_q;
	logic [15:0] prod_q;
	logic [15:0] tblptr_q;
	logic        run_q;
	logic [1:0]  mode_q;
	logic        prot_q;
	logic        adv;
	logic        prot_act;
	logic        tbl_int;
	logic [7:0]  fval;
	logic [3:0]  op;
	logic        wr_en;
	logic [7:0]  wr_addr;
	logic [7:0]  wr_val;
	logic        acc_wr;
	logic [7:0]  acc_val;
	logic [3:0]  flg_wr;
	logic        prod_wr;
	logic        br;
	logic [15:0] br_tgt;
	logic        tbl;
	logic        fetch_ok;
	localparam logic [7:0] RST_B = cafd_pkg::RST_BYTE;

	function automatic cafd_pkg::cafd_alu_t add8(input logic [7:0] a, input logic [7:0] b,
		input logic cin);
		logic [4:0] lo;
		logic [3:0] mid;
		logic [1:0] hi;
		cafd_pkg::cafd_alu_t r;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		mid = {1'b0, a[6:4]} + {1'b0, b[6:4]} + {3'h0, lo[4]};
		hi = {1'b0, a[7]} + {1'b0, b[7]} + {1'b0, mid[3]};
		r.res = {hi[0], mid[2:0], lo[3:0]};
		r.f.c = hi[1];
		r.f.dc = lo[4]; // RULE_16
		r.f.ov = hi[1] ^ mid[3]; // RULE_14 RULE_15
		r.f.z = (r.res == 8'h00); // RULE_16
		return r;
	endfunction : add8

	// Words beyond the on-chip size go out on the external bus in mixed mode; external mode sends every word out
	function automatic logic ext_sel(input logic [15:0] a, input logic [1:0] m);
		logic e;
		case (m)
			cafd_pkg::MODE_EXT:   e = 1'b1;
			cafd_pkg::MODE_MIXED: e = (32'(a) >= INT_WORDS);
			default:              e = 1'b0;
		endcase
		return e;
	endfunction : ext_sel

	assign adv = clk_en & run_q;
	assign op = ir_q[15:12];
	assign prot_act = prot_q & (mode_q != cafd_pkg::MODE_MIXED); // RULE_06
	assign tbl_int = !ext_sel(tblptr_q, mode_q);
	assign fetch_ok = (state_q != cafd_pkg::ST_TBL) && !br && !tbl;

	// Special registers answer in data space ahead of the memory
	always_comb begin
		if (data_raddr_q < cafd_pkg::SFR_COUNT) begin // RULE_07
			case (data_raddr_q)
				cafd_pkg::SFR_ACC:   fval = acc_q;
				cafd_pkg::SFR_FLAGS: fval = {4'h0, flags_q};
				cafd_pkg::SFR_PCL:   fval = pc_q[7:0];
				cafd_pkg::SFR_PCH:   fval = pch_q;
				cafd_pkg::SFR_PRODL: fval = prod_q[7:0];
				cafd_pkg::SFR_PRODH: fval = prod_q[15:8];
				cafd_pkg::SFR_TBLL:  fval = tblptr_q[7:0];
				default:             fval = tblptr_q[15:8];
			endcase
		end else if (data_we_q && data_waddr_q == data_raddr_q) begin
			// Write is still in flight, so forward it rather than read stale memory
			fval = data_wdata_q;
		end else begin
			fval = data_rdata;
		end
	end

	always_comb begin
		alu = '0;
		wr_en = 1'b0;
		wr_addr = ir_q[7:0];
		wr_val = RST_B;
		acc_wr = 1'b0;
		acc_val = RST_B;
		flg_wr = 4'h0;
		flg_val = flags_q;
		prod_wr = 1'b0;
		br = 1'b0;
		br_tgt = {pch_q, ir_q[7:0]};
		tbl = 1'b0;
		if (state_q == cafd_pkg::ST_RUN) begin
			case (op)
				cafd_pkg::OP_MOVWF: begin
					alu.res = acc_q;
				end
				cafd_pkg::OP_MOVF: begin
					alu.res = fval;
					alu.f.z = (fval == 8'h00); // RULE_16
					flg_wr = 4'b0100;
				end
				cafd_pkg::OP_ADDWF: begin
					alu = add8(fval, acc_q, 1'b0); // RULE_09 RULE_10
					flg_wr = 4'b1111;
				end
				cafd_pkg::OP_SUBWF: begin
					alu = add8(fval, ~acc_q, 1'b1); // RULE_10
					alu.f.c = ~alu.f.c; // RULE_13
					alu.f.dc = ~alu.f.dc; // RULE_13
					flg_wr = 4'b1111;
				end
				cafd_pkg::OP_ANDWF: begin
					alu.res = fval & acc_q; // RULE_09
					alu.f.z = (alu.res == 8'h00);
					flg_wr = 4'b0100;
				end
				cafd_pkg::OP_IORWF: begin
					alu.res = fval | acc_q;
					alu.f.z = (alu.res == 8'h00);
					flg_wr = 4'b0100;
				end
				cafd_pkg::OP_XORWF: begin
					alu.res = fval ^ acc_q;
					alu.f.z = (alu.res == 8'h00);
					flg_wr = 4'b0100;
				end
				cafd_pkg::OP_RLCF: begin
					alu.res = {fval[6:0], flags_q.c}; // RULE_10
					alu.f.c = fval[7];
					flg_wr = 4'b0001;
				end
				cafd_pkg::OP_RRCF: begin
					alu.res = {flags_q.c, fval[7:1]};
					alu.f.c = fval[0];
					flg_wr = 4'b0001;
				end
				cafd_pkg::OP_MULWF: begin
					prod_wr = 1'b1; // RULE_11
				end
				cafd_pkg::OP_MOVFF: begin
					wr_en = 1'b1; // RULE_08
					wr_addr = {4'h0, ir_q[11:8]};
					wr_val = fval;
				end
				cafd_pkg::OP_ADDLW: begin
					alu = add8(ir_q[7:0], acc_q, 1'b0);
					flg_wr = 4'b1111; // RULE_12
					acc_wr = 1'b1;
					acc_val = alu.res;
				end
				cafd_pkg::OP_GOTO: begin
					br = 1'b1; // RULE_03
				end
				cafd_pkg::OP_TBLRD: begin
					tbl = 1'b1; // RULE_03
				end
				cafd_pkg::OP_TBLWT: begin
					tbl = 1'b1;
				end
				default: begin
				end
			endcase
			flg_val = alu.f;
			if (op >= cafd_pkg::OP_MOVWF && op <= cafd_pkg::OP_RRCF) begin
				if (op == cafd_pkg::OP_MOVWF || ir_q[cafd_pkg::DEST_BIT]) begin
					wr_en = 1'b1;
					wr_val = alu.res;
				end else begin
					acc_wr = 1'b1;
					acc_val = alu.res;
				end
			end
		end else if (state_q == cafd_pkg::ST_TBL && op == cafd_pkg::OP_TBLRD) begin
			wr_en = 1'b1;
			// Protected internal words read back as zero
			if (prot_act && tbl_int) begin // RULE_06
				wr_val = RST_B;
			end else begin
				wr_val = ir_q[cafd_pkg::DEST_BIT] ? prog_rdata[15:8] : prog_rdata[7:0];
			end
		end
		if (wr_en && wr_addr == cafd_pkg::SFR_PCL) begin
			br = 1'b1; // RULE_07
			br_tgt = {pch_q, wr_val};
		end
	end

	// Fetch of the next word overlaps execution of the current one
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_q <= cafd_pkg::ST_FLUSH;
			pc_q <= cafd_pkg::RST_WORD;
			prog_addr_q <= cafd_pkg::RST_WORD;
			prog_ext_q <= 1'b0;
			ir_q <= cafd_pkg::RST_WORD;
			data_raddr_q <= RST_B;
		end else if (adv) begin
			if (fetch_ok) begin
				ir_q <= prog_rdata; // RULE_01 RULE_02
				data_raddr_q <= prog_rdata[7:0];
			end
			if (br) begin
				pc_q <= br_tgt; // RULE_04
				prog_addr_q <= br_tgt;
				prog_ext_q <= ext_sel(br_tgt, mode_q);
				state_q <= cafd_pkg::ST_FLUSH; // RULE_03
			end else if (tbl) begin
				prog_addr_q <= tblptr_q;
				prog_ext_q <= ext_sel(tblptr_q, mode_q);
				state_q <= cafd_pkg::ST_TBL; // RULE_03
			end else begin
				case (state_q)
					cafd_pkg::ST_TBL: begin
						prog_addr_q <= pc_q;
						prog_ext_q <= ext_sel(pc_q, mode_q);
						state_q <= cafd_pkg::ST_FLUSH;
					end
					default: begin
						pc_q <= pc_q + 16'h0001; // RULE_04
						prog_addr_q <= pc_q + 16'h0001;
						prog_ext_q <= ext_sel(pc_q + 16'h0001, mode_q); // RULE_05
						state_q <= cafd_pkg::ST_RUN;
					end
				endcase
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			acc_q <= RST_B;
		end else if (adv) begin
			if (wr_en && wr_addr == cafd_pkg::SFR_ACC) begin
				acc_q <= wr_val; // RULE_07
			end else if (acc_wr) begin
				acc_q <= acc_val; // RULE_09
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			flags_q <= '0;
		end else if (adv) begin
			if (wr_en && wr_addr == cafd_pkg::SFR_FLAGS) begin
				flags_q <= cafd_pkg::cafd_flags_t'(wr_val[3:0]);
			end else begin
				flags_q <= (flg_val & flg_wr) | (flags_q & ~flg_wr); // RULE_12
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pch_q <= RST_B;
			prod_q <= cafd_pkg::RST_WORD;
			tblptr_q <= cafd_pkg::RST_WORD;
		end else if (adv) begin
			if (prod_wr) begin
				prod_q <= 16'(acc_q * fval); // RULE_11
			end
			if (wr_en) begin
				case (wr_addr)
					cafd_pkg::SFR_PCH:   pch_q <= wr_val;
					cafd_pkg::SFR_PRODL: prod_q[7:0] <= wr_val;
					cafd_pkg::SFR_PRODH: prod_q[15:8] <= wr_val;
					cafd_pkg::SFR_TBLL:  tblptr_q[7:0] <= wr_val;
					cafd_pkg::SFR_TBLH:  tblptr_q[15:8] <= wr_val;
					default: begin
					end
				endcase
			end
		end
	end

	// Only plain file registers reach the external data bus
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			data_we_q <= 1'b0;
			data_waddr_q <= RST_B;
			data_wdata_q <= RST_B;
		end else if (clk_en) begin
			data_we_q <= adv & wr_en & (wr_addr >= cafd_pkg::SFR_COUNT);
			if (adv && wr_en) begin
				data_waddr_q <= wr_addr;
				data_wdata_q <= wr_val;
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			prog_we_q <= 1'b0;
			prog_wdata_q <= cafd_pkg::RST_WORD;
		end else if (clk_en) begin
			prog_we_q <= 1'b0;
			if (adv && tbl && op == cafd_pkg::OP_TBLWT) begin
				prog_we_q <= !(prot_act && tbl_int); // RULE_06
				prog_wdata_q <= {fval, acc_q};
			end
		end
	end

	// Protection is sticky: once set only reset lifts it
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			run_q <= 1'b0;
			mode_q <= cafd_pkg::MODE_INT;
			prot_q <= 1'b0;
		end else if (clk_en && sw_wr && sw_addr == cafd_pkg::REG_CTRL) begin
			run_q <= sw_wdata[cafd_pkg::CTRL_RUN];
			mode_q <= sw_wdata[cafd_pkg::CTRL_MODE +: 2]; // RULE_05
			prot_q <= prot_q | sw_wdata[cafd_pkg::CTRL_PROT];
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sw_rdata_q <= RST_B;
		end else if (clk_en) begin
			sw_rdata_q <= RST_B;
			if (sw_rd) begin
				case (sw_addr)
					cafd_pkg::REG_CTRL:   sw_rdata_q <= {4'h0, prot_q, mode_q, run_q};
					cafd_pkg::REG_STATUS: sw_rdata_q <= {2'b00, state_q, flags_q};
					cafd_pkg::REG_ACC:    sw_rdata_q <= acc_q;
					cafd_pkg::REG_PCL:    sw_rdata_q <= pc_q[7:0];
					cafd_pkg::REG_PCH:    sw_rdata_q <= pc_q[15:8];
					cafd_pkg::REG_PRODL:  sw_rdata_q <= prod_q[7:0];
					cafd_pkg::REG_PRODH:  sw_rdata_q <= prod_q[15:8];
					default:              sw_rdata_q <= RST_B;
				endcase
			end
		end
	end
endmodule : cafd_core

// >>> design/cafd_pkg.sv
// What this block does
// RULE_01: Each instruction word is 16 bits and one whole word is fetched per instruction cycle.
// RULE_02: The next instruction is fetched while the current one executes, in a two-stage pipe.
// RULE_03: Instructions take one cycle, except branches and the two table transfers.
// RULE_04: The instruction pointer is 16 bits wide and reaches 64K words of 16 bits.
// RULE_05: Program fetch runs internal only, locked internal, external only or mixed.
// RULE_06: Mixed mode never applies code protection to program memory.
// RULE_07: Special registers, accumulator and instruction pointer among them, sit in data space.
// RULE_08: A two-register move copies a byte file to file without touching the accumulator.
// RULE_09: The ALU works between the 8-bit accumulator and any file register.
// RULE_10: The ALU is 8 bits and adds, subtracts, shifts and does logic in two's complement.
// RULE_11: The multiplier takes two bytes and gives the full 16-bit product in one cycle.
// RULE_12: ALU operations update the carry, nibble, zero and signed-wrap flags per instruction.
// RULE_13: In subtraction the carry and nibble flags report a borrow out of bit 7 and bit 3.
// RULE_14: The signed-wrap flag is set when a signed result leaves the range -128 to 127.
// RULE_15: The signed-wrap flag comes only from the carries into and out of bit 7 of the byte.
// RULE_16: The zero flag marks a zero result and the nibble flag the carry from bit 3 to bit 4.
package cafd_pkg;
	localparam int DW = 8;
	localparam int IW = 16;
	localparam int AW = 16;
	localparam int INT_WORDS = 16384;

	localparam logic [3:0] OP_NOP   = 4'h0;
	localparam logic [3:0] OP_MOVWF = 4'h1;
	localparam logic [3:0] OP_MOVF  = 4'h2;
	localparam logic [3:0] OP_ADDWF = 4'h3;
	localparam logic [3:0] OP_SUBWF = 4'h4;
	localparam logic [3:0] OP_ANDWF = 4'h5;
	localparam logic [3:0] OP_IORWF = 4'h6;
	localparam logic [3:0] OP_XORWF = 4'h7;
	localparam logic [3:0] OP_RLCF  = 4'h8;
	localparam logic [3:0] OP_RRCF  = 4'h9;
	localparam logic [3:0] OP_MULWF = 4'ha;
	localparam logic [3:0] OP_MOVFF = 4'hb;
	localparam logic [3:0] OP_ADDLW = 4'hc;
	localparam logic [3:0] OP_GOTO  = 4'hd;
	localparam logic [3:0] OP_TBLRD = 4'he;
	localparam logic [3:0] OP_TBLWT = 4'hf;
	localparam int DEST_BIT = 8;

	localparam logic [7:0] SFR_ACC   = 8'h00;
	localparam logic [7:0] SFR_FLAGS = 8'h01;
	localparam logic [7:0] SFR_PCL   = 8'h02;
	localparam logic [7:0] SFR_PCH   = 8'h03;
	localparam logic [7:0] SFR_PRODL = 8'h04;
	localparam logic [7:0] SFR_PRODH = 8'h05;
	localparam logic [7:0] SFR_TBLL  = 8'h06;
	localparam logic [7:0] SFR_TBLH  = 8'h07;
	localparam logic [7:0] SFR_COUNT = 8'h08;

	localparam logic [2:0] REG_CTRL   = 3'h0;
	localparam logic [2:0] REG_STATUS = 3'h1;
	localparam logic [2:0] REG_ACC    = 3'h2;
	localparam logic [2:0] REG_PCL    = 3'h3;
	localparam logic [2:0] REG_PCH    = 3'h4;
	localparam logic [2:0] REG_PRODL  = 3'h5;
	localparam logic [2:0] REG_PRODH  = 3'h6;
	localparam int CTRL_RUN  = 0;
	localparam int CTRL_MODE = 1;
	localparam int CTRL_PROT = 3;

	localparam logic [1:0] MODE_INT    = 2'b00;
	localparam logic [1:0] MODE_LOCKED = 2'b01;
	localparam logic [1:0] MODE_EXT    = 2'b10;
	localparam logic [1:0] MODE_MIXED  = 2'b11;

	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;

	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_FLUSH = 2'b01,
		ST_TBL   = 2'b10
	} cafd_state_t;

	typedef struct packed {
		logic ov;
		logic z;
		logic dc;
		logic c;
	} cafd_flags_t;

	typedef struct packed {
		logic [7:0]  res;
		cafd_flags_t f;
	} cafd_alu_t;
endpackage : cafd_pkg

// >>> testbench/cafd_core_assertions.sv
`timescale 1ns/1ps
module cafd_core_assertions #(
	parameter int INT_WORDS = cafd_pkg::INT_WORDS
) (
	input	wire logic		mclk,
	input	wire logic		nrst,
	input	wire logic		clk_en,
	input	wire logic [15:0]	prog_addr_q,
	input	wire logic		prog_ext_q,
	input	wire logic [15:0]	prog_rdata,
	input	wire logic		prog_we_q,
	input	wire logic [7:0]	data_waddr_q,
	input	wire logic		data_we_q,
	input	wire logic [2:0]	sw_addr,
	input	wire logic [7:0]	sw_wdata,
	input	wire logic		sw_wr,
	input	wire logic		sw_rd,
	input	wire logic [7:0]	sw_rdata_q
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	logic		run_q;
	logic		prot_q;
	logic [1:0]	mode_q;
	logic [2:0]	v_q;
	logic [15:0]	w1_q;
	logic [15:0]	w2_q;
	logic [15:0]	w3_q;
	logic		adv;
	logic		seq_ok;
	function automatic logic plain(input logic [15:0] w);
		return w[15:12] < cafd_pkg::OP_GOTO && w[7:0] > cafd_pkg::SFR_PCH && w[11:9] == 3'h0;
	endfunction : plain
	// Control shadow: the core is only visible through its ports
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			run_q <= 1'b0;
			mode_q <= 2'b00;
			prot_q <= 1'b0;
		end else if (clk_en && sw_wr && sw_addr == cafd_pkg::REG_CTRL) begin
			run_q <= sw_wdata[0];
			mode_q <= sw_wdata[2:1];
			prot_q <= prot_q | sw_wdata[3];
		end
	end
	// Fetch history, so that branch and table cycles are left out of the step check
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			v_q <= 3'h0;
			w1_q <= 16'h0000;
			w2_q <= 16'h0000;
			w3_q <= 16'h0000;
		end else if (clk_en) begin
			v_q <= run_q ? {v_q[1:0], 1'b1} : 3'h0;
			w1_q <= prog_rdata;
			w2_q <= w1_q;
			w3_q <= w2_q;
		end
	end
	assign adv = clk_en && run_q;
	assign seq_ok = v_q == 3'h7 && plain(w1_q) && plain(w2_q) && plain(w3_q);
	sequence goto_s;
		adv && v_q[1:0] == 2'h3 && plain(w1_q) && plain(w2_q)
			&& prog_rdata[15:12] == cafd_pkg::OP_GOTO ##1 adv;
	endsequence
	fetch_step_a: assert property (
		adv && seq_ok |=> prog_addr_q == $past(prog_addr_q) + 16'h1)
		else $error("fetch address did not step by one");
	goto_target_a: assert property (
		goto_s |=> prog_addr_q[7:0] == $past(prog_rdata[7:0], 2))
		else $error("branch target not fetched");
	int_no_ext_a: assert property (
		run_q && !mode_q[1] |-> !prog_ext_q)
		else $error("internal mode went external");
	mixed_ext_a: assert property (
		run_q && mode_q == cafd_pkg::MODE_MIXED |-> prog_ext_q == (int'(prog_addr_q) >= INT_WORDS))
		else $error("mixed mode bus select wrong");
	ext_only_a: assert property (
		run_q && $past(run_q, 2) && mode_q == cafd_pkg::MODE_EXT |-> prog_ext_q)
		else $error("external mode fetched internally");
	prot_wr_a: assert property (
		prog_we_q && prot_q |-> mode_q == cafd_pkg::MODE_MIXED || prog_ext_q)
		else $error("protected internal word written");
	ctrl_rd_a: assert property (
		clk_en && sw_wr && sw_addr == cafd_pkg::REG_CTRL ##1 clk_en && sw_rd
			&& sw_addr == cafd_pkg::REG_CTRL |=> sw_rdata_q[2:0] == $past(sw_wdata[2:0], 2))
		else $error("control readback wrong");
	data_wr_a: assert property (
		data_we_q |-> data_waddr_q >= cafd_pkg::SFR_COUNT)
		else $error("special register written to data memory");
	freeze_a: assert property (
		!clk_en |=> $stable(prog_addr_q) && $stable(prog_ext_q) && $stable(data_we_q))
		else $error("core moved while frozen");
endmodule : cafd_core_assertions

bind cafd_core cafd_core_assertions #(.INT_WORDS(INT_WORDS)) u_chk (
	.mclk(mclk), .nrst(nrst), .clk_en(clk_en), .prog_addr_q(prog_addr_q),
	.prog_ext_q(prog_ext_q), .prog_rdata(prog_rdata), .prog_we_q(prog_we_q),
	.data_waddr_q(data_waddr_q), .data_we_q(data_we_q), .sw_addr(sw_addr),
	.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata_q(sw_rdata_q));

// >>> testbench/cafd_mem_model.sv
`timescale 1ns/1ps
module cafd_mem_model (
	input	wire logic		mclk,
	input	wire logic [15:0]	prog_addr_q,
	output	logic [15:0]		prog_rdata,
	input	wire logic [15:0]	prog_wdata_q,
	input	wire logic		prog_we_q,
	input	wire logic [7:0]	data_raddr_q,
	output	logic [7:0]		data_rdata,
	input	wire logic [7:0]	data_waddr_q,
	input	wire logic [7:0]	data_wdata_q,
	input	wire logic		data_we_q
);
	logic [15:0]	prog_mem [65536];
	logic [7:0]	data_mem [256];
	// Zero wait: one array serves internal and external program space alike
	assign prog_rdata = prog_mem[prog_addr_q];
	assign data_rdata = data_mem[data_raddr_q];
	always @(posedge mclk) begin
		if (prog_we_q)
			prog_mem[prog_addr_q] <= prog_wdata_q;
		if (data_we_q)
			data_mem[data_waddr_q] <= data_wdata_q;
	end
endmodule : cafd_mem_model

// >>> testbench/tb_cafd_core.sv
`timescale 1ns/1ps
module tb_cafd_core;
	logic		mclk;
	logic		nrst;
	logic		clk_en;
	logic [15:0]	prog_addr_q;
	logic		prog_ext_q;
	logic [15:0]	prog_rdata;
	logic [15:0]	prog_wdata_q;
	logic		prog_we_q;
	logic [7:0]	data_raddr_q;
	logic [7:0]	data_rdata;
	logic [7:0]	data_waddr_q;
	logic [7:0]	data_wdata_q;
	logic		data_we_q;
	logic [2:0]	sw_addr;
	logic [7:0]	sw_wdata;
	logic		sw_wr;
	logic		sw_rd;
	logic [7:0]	sw_rdata_q;
	logic [7:0]	v;
	int		err_count;
	int		check_count;
	// Four internal words, so short programs cross into external space in mixed mode
	cafd_core #(.INT_WORDS(4)) dut (
		.mclk(mclk), .nrst(nrst), .clk_en(clk_en), .prog_addr_q(prog_addr_q),
		.prog_ext_q(prog_ext_q), .prog_rdata(prog_rdata), .prog_wdata_q(prog_wdata_q),
		.prog_we_q(prog_we_q), .data_raddr_q(data_raddr_q), .data_rdata(data_rdata),
		.data_waddr_q(data_waddr_q), .data_wdata_q(data_wdata_q), .data_we_q(data_we_q),
		.sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
		.sw_rdata_q(sw_rdata_q));
	cafd_mem_model mem (
		.mclk(mclk), .prog_addr_q(prog_addr_q), .prog_rdata(prog_rdata),
		.prog_wdata_q(prog_wdata_q), .prog_we_q(prog_we_q), .data_raddr_q(data_raddr_q),
		.data_rdata(data_rdata), .data_waddr_q(data_waddr_q), .data_wdata_q(data_wdata_q),
		.data_we_q(data_we_q));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge mclk);
		sw_wr <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge mclk);
		sw_rd <= 1'b0;
		#1 v = sw_rdata_q;
		@(posedge mclk);
	endtask : rd
	task automatic run_prog(input logic [63:0] p, input logic [3:0] c, input logic [7:0] acc,
			input logic [3:0] flg, input logic [15:0] prod, input logic [15:0] w2,
			input logic [7:0] da, input logic [7:0] dv);
		nrst <= 1'b0;
		for (int i = 0; i < 4; i++)
			mem.prog_mem[i] = p[63 - 16 * i -: 16];
		mem.data_mem[8'h10] = 8'h10;
		mem.data_mem[8'h11] = 8'hff;
		mem.data_mem[8'h13] = 8'h81;
		mem.data_mem[8'h14] = 8'h5a;
		// Nonzero seed, so a missing store to this byte shows up
		mem.data_mem[8'h30] = 8'h33;
		@(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		wr(cafd_pkg::REG_CTRL, {4'h0, c});
		repeat (2) @(posedge mclk);
		clk_en <= 1'b0;
		repeat (3) @(posedge mclk);
		clk_en <= 1'b1;
		repeat (20) @(posedge mclk);
		rd(cafd_pkg::REG_ACC);
		check("accumulator", {8'h0, v}, {8'h0, acc});
		rd(cafd_pkg::REG_STATUS);
		check("flags", {12'h0, v[3:0]}, {12'h0, flg});
		rd(cafd_pkg::REG_PRODL);
		check("product low", {8'h0, v}, {8'h0, prod[7:0]});
		rd(cafd_pkg::REG_PRODH);
		check("product high", {8'h0, v}, {8'h0, prod[15:8]});
		rd(cafd_pkg::REG_CTRL);
		check("control", {12'h0, v[3:0]}, {12'h0, c});
		check("program word", mem.prog_mem[2], w2);
		check("data byte", {8'h0, mem.data_mem[da]}, {8'h0, dv});
	endtask : run_prog
	initial begin
		nrst = 1'b0;
		clk_en = 1'b1;
		sw_addr = 3'h0;
		sw_wdata = 8'h00;
		sw_wr = 1'b0;
		sw_rd = 1'b0;
		err_count = 0;
		check_count = 0;
		for (int i = 0; i < 65536; i++)
			mem.prog_mem[i] = 16'h0000;
		for (int i = 0; i < 256; i++)
			mem.data_mem[i] = 8'h00;
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		wr(cafd_pkg::REG_CTRL, 8'h06);
		rd(cafd_pkg::REG_CTRL);
		check("control", {8'h0, v}, 16'h0006);
		rd(3'h7);
		check("unmapped", {8'h0, v}, 16'h0000);
		run_prog(64'hc07fc0011120d003, 4'h1, 8'h80, 4'ha, 16'h0, 16'h1120, 8'h20, 8'h80);
		run_prog(64'hc0ffc0011130d003, 4'h3, 8'h00, 4'h7, 16'h0, 16'h1130, 8'h30, 8'h00);
		run_prog(64'hc00140101130d003, 4'h5, 8'h0f, 4'h2, 16'h0, 16'h1130, 8'h30, 8'h0f);
		run_prog(64'hc02040101130d003, 4'h7, 8'hf0, 4'h1, 16'h0, 16'h1130, 8'h30, 8'hf0);
		run_prog(64'hc0ffa0111130d003, 4'h1, 8'hff, 4'h0, 16'hfe01, 16'h1130, 8'h30, 8'hff);
		run_prog(64'h8013bc101130d003, 4'h1, 8'h02, 4'h1, 16'h0, 16'h1130, 8'h0c, 8'h10);
		run_prog(64'hc05a70141130d003, 4'h1, 8'h00, 4'h4, 16'h0, 16'h1130, 8'h14, 8'h5a);
		run_prog(64'hc0021106f010d003, 4'hf, 8'h02, 4'h0, 16'h0, 16'h1002, 8'h10, 8'h10);
		run_prog(64'hc0021106f010d003, 4'h9, 8'h02, 4'h0, 16'h0, 16'hf010, 8'h10, 8'h10);
		run_prog(64'h601050139113d003, 4'h1, 8'h00, 4'h5, 16'h0, 16'h9113, 8'h13, 8'h40);
		run_prog(64'hc0011106e120d003, 4'h1, 8'h01, 4'h0, 16'h0, 16'he120, 8'h20, 8'h11);
		run_prog(64'hc0011106e120d003, 4'h9, 8'h01, 4'h0, 16'h0, 16'he120, 8'h20, 8'h00);
		run_prog(64'h20151102c001d003, 4'h1, 8'h00, 4'h4, 16'h0, 16'hc001, 8'h30, 8'h33);
		stop_test();
	end
	// About 500 cycles are needed; a hang is cut off well past that
	initial begin
		repeat (2000) @(posedge mclk);
		err_count++;
		stop_test();
	end
endmodule : tb_cafd_core
